//--- hdl/bank_store.sv
// banked link and saved status storage with a registered read port
`timescale 1ns/1ps
`default_nettype none
module bank_store
    import exc_pkg::*;
#(
    parameter int DW = 64,
    parameter int AW = 3
)(
    input  wire logic          core_clk_in,
    input  wire logic          clk_en_in,
    input  wire logic          we_in,
    input  wire logic [AW-1:0] waddr_in,
    input  wire logic [DW-1:0] wdata_in,
    input  wire logic [AW-1:0] raddr_in,
    output logic      [DW-1:0] rdata_out
);
    logic [DW-1:0] mem [0:(1<<AW)-1];  // contents undefined until written
    logic [DW-1:0] rdata_q;            // registered read data

    // read first, read one cycle late; a same-address write is seen next cycle
    always_ff @(posedge core_clk_in)
    begin
        if (clk_en_in)
        begin
            if (we_in)
            begin
                mem[waddr_in] <= wdata_in;
            end
            rdata_q <= mem[raddr_in];
        end
    end

    assign rdata_out = rdata_q;
endmodule
`default_nettype wire

//--- hdl/exc_pkg.sv
// constants, types and decode helpers shared by the exception unit files
package exc_pkg;

    // mode field encodings
    localparam logic [4:0] MODE_USER   = 5'h10;
    localparam logic [4:0] MODE_FIQ    = 5'h11;
    localparam logic [4:0] MODE_IRQ    = 5'h12;
    localparam logic [4:0] MODE_SVC    = 5'h13;
    localparam logic [4:0] MODE_ABT    = 5'h17;
    localparam logic [4:0] MODE_UNDEF  = 5'h1B;
    localparam logic [4:0] MODE_SYSTEM = 5'h1F;

    // status word bit positions
    localparam int PSR_I = 7;
    localparam int PSR_F = 6;
    localparam int PSR_T = 5;
    localparam int PSR_MODE_MSB = 4;

    // status word after reset: supervisor, both masks set, full state
    localparam logic [31:0] STATUS_RST = 32'h000000D3;

    // vector addresses
    localparam logic [31:0] VEC_RESET  = 32'h00000000;
    localparam logic [31:0] VEC_UNDEF  = 32'h00000004;
    localparam logic [31:0] VEC_TRAP   = 32'h00000008;
    localparam logic [31:0] VEC_FETCH  = 32'h0000000C;
    localparam logic [31:0] VEC_ACCESS = 32'h00000010;
    localparam logic [31:0] VEC_RSVD   = 32'h00000014;
    localparam logic [31:0] VEC_IRQ    = 32'h00000018;
    localparam logic [31:0] VEC_FIQ    = 32'h0000001C;

    // link offsets added to the instruction address
    localparam logic [31:0] LINK_OFF_WORD   = 32'h00000004;
    localparam logic [31:0] LINK_OFF_ACCESS = 32'h00000008;
    localparam logic [31:0] LINK_OFF_HALF   = 32'h00000002;

    // register byte offsets on the bus
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_SAVED  = 8'h04;
    localparam logic [7:0] REG_LINK   = 8'h08;
    localparam logic [7:0] REG_RETURN = 8'h0C;
    localparam logic [7:0] REG_CAUSE  = 8'h10;

    // data access kinds
    localparam logic [1:0] ACC_SINGLE = 2'h0;
    localparam logic [1:0] ACC_SWAP   = 2'h1;
    localparam logic [1:0] ACC_BLOCK  = 2'h2;

    // bus encodings
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // exception causes
    typedef enum logic [2:0] {
        CAUSE_NONE, CAUSE_RESET, CAUSE_ACCESS, CAUSE_FIQ,
        CAUSE_IRQ, CAUSE_FETCH, CAUSE_UNDEF, CAUSE_TRAP
    } cause_t;

    // entry sequencer states
    typedef enum logic {ST_RUN, ST_ENTER} seq_state_t;

    // pending exception sources, highest priority first
    typedef struct packed {
        logic access;
        logic fiq;
        logic irq;
        logic fetch;
        logic undef;
        logic trap;
    } pend_t;

    // banked slot of a mode; zero means the mode has no saved copy
    function automatic logic [2:0] bank_of(input logic [4:0] m);
        case (m)
            MODE_FIQ:   bank_of = 3'h1;
            MODE_IRQ:   bank_of = 3'h2;
            MODE_SVC:   bank_of = 3'h3;
            MODE_ABT:   bank_of = 3'h4;
            MODE_UNDEF: bank_of = 3'h5;
            default:    bank_of = 3'h0;
        endcase
    endfunction

    // only the seven listed encodings are legal modes
    function automatic logic mode_legal(input logic [4:0] m);
        mode_legal = (m == MODE_USER) || (m == MODE_SYSTEM) || (bank_of(m) != 3'h0);
    endfunction

endpackage

//--- hdl/exc_unit.sv
// exception entry and return sequencer with an AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
// Operation
// - link gets next-instruction address on entry
// - compressed-state entry adjusts saved link value
// - current status copied to entered mode's save
// - mode field forced per exception kind
// - fetch redirected to vector; 0x14 reserved
// - fixed vector address for each exception
// - entry masks normal; fast entry masks fast too
// - compressed state cleared when vector loads
// - return restores state flag from saved copy
// - link offsets per exception and state
// - fast request is active-low level
// - select low adds synchroniser on both requests
// - fast request tested at each instruction end
// - normal request below fast, masked on fast
// - normal mask blocks; privileged modes only
// - abort classed as fetch or data fault
// - fetch fault raised only when executed
// - single transfer still writes back base
// - aborted swap leaves state unchanged
// - block transfer finishes, later overwrites suppressed
// - unknown opcode takes the undefined trap
// - software trap enters supervisor at vector
// - fixed priority among pending exceptions
// - reset gives supervisor, masks, full state, 0
// - status holds fast and normal masks
// - mode encodings fixed, others illegal
module exc_unit
    import exc_pkg::*;
(
    input  wire logic        core_clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        clk_en_in,
    input  wire logic        fast_request_n_in,
    input  wire logic        normal_request_n_in,
    input  wire logic        sync_select_in,
    input  wire logic        boundary_in,
    input  wire logic [31:0] pc_in,
    input  wire logic        unknown_opcode_in,
    input  wire logic        software_trap_in,
    input  wire logic        abort_in,
    input  wire logic        mem_cycle_in,
    input  wire logic        mem_fetch_in,
    input  wire logic        exec_advance_in,
    input  wire logic        flush_in,
    input  wire logic [1:0]  access_kind_in,
    input  wire logic        base_wb_req_in,
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic        hready_in,
    input  wire logic [31:0] hwdata_in,
    output logic      [31:0] hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    output logic             fetch_redirect_out,
    output logic      [31:0] fetch_addr_out,
    output logic      [31:0] current_status_word_out,
    output logic      [31:0] link_register_out,
    output logic             link_write_out,
    output logic             base_writeback_out,
    output logic             reg_write_suppress_out,
    output logic             swap_cancel_out
);
    // state
    seq_state_t  state_q;        // entry sequencer
    cause_t      cause_q;        // exception being or last entered
    logic [31:0] status_q;       // current status word
    logic [31:0] link_q;         // link value computed at take
    logic [4:0]  new_mode_q;     // mode being entered
    logic [31:0] vector_q;       // vector of the taken exception
    logic        link_we_q;      // high during the entry write cycle
    logic        redirect_q;     // one-cycle fetch redirect
    logic [31:0] fetch_addr_q;   // target of the redirect
    logic        access_pend_q;  // data fault waiting for the boundary
    logic        fetch_tag_q;    // fetched instruction marked invalid
    logic        exec_tag_q;     // executing instruction marked invalid
    logic        suppress_q;     // register overwrites blocked
    logic        swap_cancel_q;  // swap discarded
    logic        base_wb_q;      // base write-back allowed
    logic        ap_valid_q;     // bus data phase pending
    logic        ap_write_q;     // pending phase is a write
    logic        ap_word_q;      // pending phase is a whole word
    logic [7:0]  ap_addr_q;      // pending register offset
    logic [31:0] hrdata_q;       // registered read data

    // synchronised request levels
    logic [1:0]  req_n;
    logic [63:0] bank_rd;

    // both requests share one synchroniser and one select
    req_sync #(
        .W (2)
    ) u_sync (
        .core_clk_in    (core_clk_in),
        .sys_rst_in     (sys_rst_in),
        .clk_en_in      (clk_en_in),
        .sync_select_in (sync_select_in),
        .req_n_in       ({fast_request_n_in, normal_request_n_in}),
        .req_n_out      (req_n)
    );

    // decode of the pending sources
    wire   user_mode  = (status_q[PSR_MODE_MSB:0] == MODE_USER);
    wire   compressed = status_q[PSR_T];
    wire   abort_mem  = abort_in & mem_cycle_in;
    wire   abort_data = abort_mem & ~mem_fetch_in;
    wire   abort_fetch = abort_mem & mem_fetch_in;
    pend_t pend;

    // levels go straight in, no capture, so a released request is dropped
    assign pend.access = access_pend_q;
    assign pend.fiq    = ~req_n[1] & ~status_q[PSR_F];
    assign pend.irq    = ~req_n[0] & ~status_q[PSR_I];
    assign pend.fetch  = exec_tag_q;
    assign pend.undef  = unknown_opcode_in;
    assign pend.trap   = software_trap_in;

    // fixed order: data fault, fast, normal, fetch fault, opcode traps
    wire cause_t cause_sel = pend.access ? CAUSE_ACCESS :
                             pend.fiq    ? CAUSE_FIQ :
                             pend.irq    ? CAUSE_IRQ :
                             pend.fetch  ? CAUSE_FETCH :
                             pend.undef  ? CAUSE_UNDEF :
                             pend.trap   ? CAUSE_TRAP : CAUSE_NONE;
    wire take = clk_en_in & (state_q == ST_RUN) & boundary_in & (cause_sel != CAUSE_NONE);

    // link offset: data fault +8, opcode traps +2 in compressed state
    wire short_link = compressed & ((cause_sel == CAUSE_UNDEF) | (cause_sel == CAUSE_TRAP));
    wire [31:0] link_off = (cause_sel == CAUSE_ACCESS) ? LINK_OFF_ACCESS :
                           short_link ? LINK_OFF_HALF : LINK_OFF_WORD;
    wire [31:0] link_d = pc_in + link_off;

    // mode per exception
    wire [4:0] mode_sel = (cause_sel == CAUSE_FIQ)   ? MODE_FIQ :
                          (cause_sel == CAUSE_IRQ)   ? MODE_IRQ :
                          (cause_sel == CAUSE_UNDEF) ? MODE_UNDEF :
                          (cause_sel == CAUSE_TRAP)  ? MODE_SVC : MODE_ABT;

    // vector per exception; the reserved slot is never selected
    wire [31:0] vec_sel = (cause_sel == CAUSE_ACCESS) ? VEC_ACCESS :
                          (cause_sel == CAUSE_FIQ)    ? VEC_FIQ :
                          (cause_sel == CAUSE_IRQ)    ? VEC_IRQ :
                          (cause_sel == CAUSE_FETCH)  ? VEC_FETCH :
                          (cause_sel == CAUSE_UNDEF)  ? VEC_UNDEF : VEC_TRAP;

    // status at entry: I set always, F added for fast, T cleared
    wire entering = clk_en_in & (state_q == ST_ENTER);
    wire [31:0] entry_status = {status_q[31:8], 1'b1,
                                status_q[PSR_F] | (cause_q == CAUSE_FIQ),
                                1'b0, new_mode_q};

    // bus decode
    wire ap_take   = hsel_in & htrans_in[1] & hready_in;
    wire dp_write  = clk_en_in & ap_valid_q & ap_write_q & ap_word_q;
    wire wr_status = dp_write & (ap_addr_q == REG_STATUS) & ~user_mode;
    wire wr_return = dp_write & (ap_addr_q == REG_RETURN) &
                     (bank_of(status_q[PSR_MODE_MSB:0]) != 3'h0);
    wire new_mode_ok = mode_legal(hwdata_in[PSR_MODE_MSB:0]);
    // the state flag loads here, standing in for the core's own state switch
    wire [31:0] sw_status = {status_q[31:8], hwdata_in[PSR_I], hwdata_in[PSR_F], hwdata_in[PSR_T],
                             new_mode_ok ? hwdata_in[PSR_MODE_MSB:0] : status_q[PSR_MODE_MSB:0]};
    wire [31:0] rd_mux = (haddr_in[7:0] == REG_STATUS) ? status_q :
                         (haddr_in[7:0] == REG_SAVED)  ? bank_rd[31:0] :
                         (haddr_in[7:0] == REG_LINK)   ? bank_rd[63:32] :
                         (haddr_in[7:0] == REG_CAUSE)  ? {29'h0, cause_q} : 32'h00000000;

    // banked link and saved status, read at the current mode's slot
    bank_store #(
        .DW (64),
        .AW (3)
    ) u_bank (
        .core_clk_in (core_clk_in),
        .clk_en_in   (clk_en_in),
        .we_in       (entering),
        .waddr_in    (bank_of(new_mode_q)),
        .wdata_in    ({link_q, status_q}),
        .raddr_in    (bank_of(status_q[PSR_MODE_MSB:0])),
        .rdata_out   (bank_rd)
    );

    // entry sequencer: take at a boundary, commit one cycle later
    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            state_q    <= ST_RUN;
            cause_q    <= CAUSE_RESET;
            link_q     <= 32'h00000000;
            new_mode_q <= MODE_SVC;
            vector_q   <= VEC_RESET;
            link_we_q  <= 1'b0;
        end
        else if (clk_en_in)
        begin
            link_we_q <= take;
            case (state_q)
                ST_RUN:
                begin
                    if (take)
                    begin
                        state_q    <= ST_ENTER;
                        cause_q    <= cause_sel;
                        link_q     <= link_d;
                        new_mode_q <= mode_sel;
                        vector_q   <= vec_sel;
                    end
                end
                ST_ENTER: state_q <= ST_RUN;
                default:  state_q <= ST_RUN;
            endcase
        end
    end

    // status word: reset, then entry, then return, then software write
    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
            status_q <= STATUS_RST;
        else if (entering)
            status_q <= entry_status;
        else if (wr_return)
            status_q <= bank_rd[31:0];
        else if (wr_status)
            status_q <= sw_status;
    end

    // fetch redirect: vector on entry, written target on return
    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            redirect_q   <= 1'b1;
            fetch_addr_q <= VEC_RESET;
        end
        else if (clk_en_in)
        begin
            redirect_q <= entering | wr_return;
            if (entering)
            begin
                fetch_addr_q <= vector_q;
            end
            else if (wr_return)
            begin
                fetch_addr_q <= hwdata_in;
            end
        end
    end

    // fault tracking; a new fault wins over a same-cycle clear
    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            access_pend_q <= 1'b0;
            fetch_tag_q   <= 1'b0;
            exec_tag_q    <= 1'b0;
        end
        else if (clk_en_in)
        begin
            access_pend_q <= abort_data | (access_pend_q & ~(take & (cause_sel == CAUSE_ACCESS)));
            // flushed fetches lose their mark, so the fault never fires
            fetch_tag_q   <= abort_fetch | (fetch_tag_q & ~flush_in & ~exec_advance_in);
            if (exec_advance_in)
            begin
                exec_tag_q <= fetch_tag_q & ~flush_in;
            end
            else if (take & (cause_sel == CAUSE_FETCH))
            begin
                exec_tag_q <= 1'b0;
            end
        end
    end

    // write-back control for aborted data transfers
    wire swap_hit  = abort_data & (access_kind_in == ACC_SWAP);
    wire block_hit = abort_data & (access_kind_in == ACC_BLOCK);
    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            suppress_q    <= 1'b0;
            swap_cancel_q <= 1'b0;
            base_wb_q     <= 1'b0;
        end
        else if (clk_en_in)
        begin
            // later register overwrites, program counter included, are blocked; base write-back is blocked for a swap only
            suppress_q    <= block_hit | swap_hit | (suppress_q & ~boundary_in);
            swap_cancel_q <= swap_hit | (swap_cancel_q & ~boundary_in);
            // single and block keep their base update; a swap does not
            base_wb_q     <= base_wb_req_in & ~swap_hit & ~swap_cancel_q;
        end
    end

    // bus slave: zero wait states, always OKAY, reads taken in the address phase
    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            ap_valid_q <= 1'b0;
            ap_write_q <= 1'b0;
            ap_word_q  <= 1'b0;
            ap_addr_q  <= 8'h00;
            hrdata_q   <= 32'h00000000;
        end
        else if (clk_en_in)
        begin
            ap_valid_q <= ap_take;
            ap_write_q <= hwrite_in;
            ap_word_q  <= (hsize_in == HSIZE_WORD) & (haddr_in[31:8] == 24'h000000);
            ap_addr_q  <= haddr_in[7:0];
            if (ap_take & ~hwrite_in)
            begin
                hrdata_q <= rd_mux;
            end
        end
    end

    assign hrdata_out              = hrdata_q;
    assign hreadyout_out           = 1'b1;
    assign hresp_out               = 1'b0;
    assign fetch_redirect_out      = redirect_q;
    assign fetch_addr_out          = fetch_addr_q;
    assign current_status_word_out = status_q;
    assign link_register_out       = link_q;
    assign link_write_out          = link_we_q;
    assign base_writeback_out      = base_wb_q;
    assign reg_write_suppress_out  = suppress_q;
    assign swap_cancel_out         = swap_cancel_q;

    // checks
    AST_LINK_ACCESS: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        take & (cause_sel == CAUSE_ACCESS) |=> link_q == $past(pc_in) + LINK_OFF_ACCESS)
        else $error("data fault link is not pc plus 8");
    AST_LINK_HALF: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        take & compressed & (cause_sel == CAUSE_TRAP) |=> link_q == $past(pc_in) + LINK_OFF_HALF)
        else $error("compressed trap link is not pc plus 2");
    AST_SAVE: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        entering |=> bank_of(status_q[4:0]) == $past(bank_of(new_mode_q)))
        else $error("entry did not reach the saved mode");
    AST_FIQ_MODE: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        take & (cause_sel == CAUSE_FIQ) |=> ##1 status_q[4:0] == MODE_FIQ && status_q[PSR_I] && status_q[PSR_F])
        else $error("fast entry mode or masks wrong");
    AST_REDIRECT: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        take & clk_en_in |=> ##1 redirect_q && fetch_addr_q == $past(vec_sel, 2))
        else $error("vector redirect missing");
    AST_NO_RSVD: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        redirect_q |-> fetch_addr_q != VEC_RSVD || $past(wr_return))
        else $error("reserved vector fetched");
    AST_STATE_CLR: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        entering |=> !status_q[PSR_T])
        else $error("compressed state kept after entry");
    AST_PRIO: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        pend.access |-> cause_sel == CAUSE_ACCESS)
        else $error("data fault not first");
    AST_IRQ_MASK: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        status_q[PSR_I] |-> cause_sel != CAUSE_IRQ)
        else $error("masked normal request taken");
    AST_SWAP: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        swap_hit & clk_en_in |=> swap_cancel_q && !base_wb_q)
        else $error("aborted swap not cancelled");
endmodule
`default_nettype wire

//--- hdl/req_sync.sv
// two-stage synchroniser for the interrupt requests with a bypass select
`timescale 1ns/1ps
`default_nettype none
module req_sync
    import exc_pkg::*;
#(
    parameter int W = 2
)(
    input  wire logic         core_clk_in,
    input  wire logic         sys_rst_in,
    input  wire logic         clk_en_in,
    input  wire logic         sync_select_in,
    input  wire logic [W-1:0] req_n_in,
    output logic      [W-1:0] req_n_out
);
    logic [W-1:0] s1_q;  // first stage, read only by the second
    logic [W-1:0] s2_q;  // second stage

    // reset to the inactive high level so no request appears at release
    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            s1_q <= '1;
            s2_q <= '1;
        end
        else if (clk_en_in)
        begin
            s1_q <= req_n_in;
            s2_q <= s1_q;
        end
    end

    // low select: asynchronous sources, take the delayed copy
    assign req_n_out = sync_select_in ? req_n_in : s2_q;
endmodule
`default_nettype wire

//--- test/cpu_exception_entry_exit_bench.sv
// self-checking bench for the exception entry unit
`timescale 1ns/1ps
`default_nettype none
module cpu_exception_entry_exit_bench;
    import exc_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, bnd = 1'b0, trap = 1'b0, uop = 1'b0;    // core controls
    logic        abt = 1'b0, mcyc = 1'b0, bw = 1'b0, sync = 1'b1, fq_n, nq_n;     // memory and requests
    logic        mf = 1'b0, adv = 1'b0, fl = 1'b0;                                // fetch marks
    logic [1:0]  ak = ACC_SINGLE;                                                 // data access kind
    logic        fiq_on = 1'b0, irq_on = 1'b0, hsel = 1'b0, hwr = 1'b0;           // source and bus
    logic [1:0]  htr = 2'h0;                                                      // transfer kind
    logic [2:0]  hsz = HSIZE_WORD;                                                // whole words only
    logic [31:0] pc = 32'h0, ha = 32'h0, hwd = 32'h0, hrd, fa, st, lk, rd;        // addresses and data
    logic        hro, hrs, redir, lw, bwb, sup, swc;                              // design outputs
    int          n_fail = 0, num_checks = 0;                                      // tallies
    always #2.5 clk = ~clk;
    irq_model src (.core_clk_in(clk), .fiq_on_in(fiq_on), .irq_on_in(irq_on),
        .fast_request_n_out(fq_n), .normal_request_n_out(nq_n));
    exc_unit uut (.core_clk_in(clk), .sys_rst_in(rst), .clk_en_in(1'b1), .fast_request_n_in(fq_n),
        .normal_request_n_in(nq_n), .sync_select_in(sync), .boundary_in(bnd), .pc_in(pc),
        .unknown_opcode_in(uop), .software_trap_in(trap), .abort_in(abt), .mem_cycle_in(mcyc),
        .mem_fetch_in(mf), .exec_advance_in(adv), .flush_in(fl), .access_kind_in(ak),
        .base_wb_req_in(bw), .hsel_in(hsel), .haddr_in(ha), .htrans_in(htr), .hwrite_in(hwr),
        .hsize_in(hsz), .hready_in(hro), .hwdata_in(hwd), .hrdata_out(hrd), .hreadyout_out(hro),
        .hresp_out(hrs), .fetch_redirect_out(redir), .fetch_addr_out(fa), .current_status_word_out(st),
        .link_register_out(lk), .link_write_out(lw), .base_writeback_out(bwb),
        .reg_write_suppress_out(sup), .swap_cancel_out(swc));
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one single transfer; read data taken at the edge that ends the data phase
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htr  <= 2'h2;
        hwr  <= w;
        ha   <= a;
        @(posedge clk);
        while (hro !== 1'b1) @(posedge clk);
        htr <= 2'h0;
        hwd <= d;
        @(posedge clk);
        while (hro !== 1'b1) @(posedge clk);
        rd = hrd;
    endtask
    // one boundary, then the link pulse and the redirect a cycle apart
    task automatic enter(input logic [31:0] p, input logic [31:0] lx, input logic [31:0] vx,
        input logic [4:0] mx);
        @(posedge clk);
        bnd <= 1'b1;
        pc  <= p;
        @(posedge clk);
        bnd  <= 1'b0;
        trap <= 1'b0;
        uop  <= 1'b0;
        #1;
        check("link_write", lw, 1'b1);
        check("link", lk, lx);
        @(posedge clk);
        #1;
        check("redirect", redir, 1'b1);
        check("vector", fa, vx);
        check("mode", st[4:0], mx);
        check("normal_mask", st[PSR_I], 1'b1);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // a hang is cut off well past the roughly 65 cycles the run needs
    initial
    begin
        #20000;
        n_fail++;
        tally_and_finish();
    end
    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        check("status", st, STATUS_RST);
        check("okay", hrs, 1'b0);
        bus(1'b0, {24'h0, REG_STATUS}, 32'h0);
        check("status_rd", rd, STATUS_RST);
        trap <= 1'b1;
        enter(32'h100, 32'h104, VEC_TRAP, MODE_SVC);
        uop <= 1'b1;
        enter(32'h200, 32'h204, VEC_UNDEF, MODE_UNDEF);
        // both masks cleared, then fast and normal together with a trap pending
        bus(1'b1, {24'h0, REG_STATUS}, 32'h13);
        fiq_on <= 1'b1;
        irq_on <= 1'b1;
        trap   <= 1'b1;
        enter(32'h300, 32'h304, VEC_FIQ, MODE_FIQ);
        check("fast_mask", st[PSR_F], 1'b1);
        fiq_on <= 1'b0;
        sync   <= 1'b0;
        bus(1'b1, {24'h0, REG_STATUS}, 32'h13);
        repeat (4) @(posedge clk);
        enter(32'h400, 32'h404, VEC_IRQ, MODE_IRQ);
        irq_on <= 1'b0;
        // data abort on a single store while a fast request waits
        bus(1'b1, {24'h0, REG_STATUS}, 32'h13);
        fiq_on <= 1'b1;
        mcyc   <= 1'b1;
        abt    <= 1'b1;
        bw     <= 1'b1;
        @(posedge clk);
        mcyc <= 1'b0;
        abt  <= 1'b0;
        bw   <= 1'b0;
        #1;
        check("base_wb", bwb, 1'b1);
        // let the fast request through the synchroniser so both are pending
        repeat (2) @(posedge clk);
        enter(32'h500, 32'h508, VEC_ACCESS, MODE_ABT);
        enter(32'h10, 32'h14, VEC_FIQ, MODE_FIQ);
        // a flushed fetch fault is dropped, one that reaches execution is taken
        fiq_on <= 1'b0;
        mf     <= 1'b1;
        mcyc   <= 1'b1;
        abt    <= 1'b1;
        @(posedge clk);
        mcyc <= 1'b0;
        abt  <= 1'b0;
        fl   <= 1'b1;
        @(posedge clk);
        fl   <= 1'b0;
        adv  <= 1'b1;
        @(posedge clk);
        adv  <= 1'b0;
        trap <= 1'b1;
        enter(32'h700, 32'h704, VEC_TRAP, MODE_SVC);
        mcyc <= 1'b1;
        abt  <= 1'b1;
        @(posedge clk);
        mcyc <= 1'b0;
        abt  <= 1'b0;
        adv  <= 1'b1;
        @(posedge clk);
        adv <= 1'b0;
        uop <= 1'b1;
        enter(32'h800, 32'h804, VEC_FETCH, MODE_ABT);
        // compressed state: short link, full state on entry, flag back on return
        bus(1'b1, {24'h0, REG_STATUS}, 32'h33);
        trap <= 1'b1;
        enter(32'h600, 32'h602, VEC_TRAP, MODE_SVC);
        check("entry_state", st[PSR_T], 1'b0);
        bus(1'b0, {24'h0, REG_SAVED}, 32'h0);
        check("saved", rd, 32'h33);
        bus(1'b1, {24'h0, REG_RETURN}, 32'h604);
        #1;
        check("resume_state", st[PSR_T], 1'b1);
        check("resume_pc", fa, 32'h604);
        // aborted swap: no base update, later overwrites blocked
        mf   <= 1'b0;
        ak   <= ACC_SWAP;
        mcyc <= 1'b1;
        abt  <= 1'b1;
        bw   <= 1'b1;
        @(posedge clk);
        mcyc <= 1'b0;
        abt  <= 1'b0;
        #1;
        check("swap_cancel", swc, 1'b1);
        check("swap_base", bwb, 1'b0);
        check("suppress", sup, 1'b1);
        tally_and_finish();
    end
endmodule
`default_nettype wire

//--- test/irq_model.sv
// interrupt source model driving the two request levels
`timescale 1ns/1ps
`default_nettype none
module irq_model (
    input  wire logic core_clk_in,
    input  wire logic fiq_on_in,
    input  wire logic irq_on_in,
    output logic      fast_request_n_out,
    output logic      normal_request_n_out
);
    // held low for as long as the source wants service, never pulsed
    always_ff @(posedge core_clk_in)
    begin
        fast_request_n_out   <= ~fiq_on_in;
        normal_request_n_out <= ~irq_on_in;
    end
endmodule
`default_nettype wire
